//--- rtl/status_report.sv
// Status-reporting logic: message status word, word monitor tag, interrupt queue
//
// Summary of operation
// - Start flag on begin; done flag on completion.
// - Bus bit one for bus B.
// - Error flag with bits 10..8; monitor bit 10 only.
// - Bit 11 marks RT-to-RT receive or monitored.
// - Bit 10 on response protocol violation.
// - Bit 9 on late or absent transmitter, RT mode.
// - Bit 8 on loopback failure in RT mode.
// - Monitor bit 8 means valid message.
// - Bit 7 on buffer rollover, valid-only option.
// - Bit 6 on illegalized command, RT mode.
// - Bit 5 on wrong data word count.
// - Bit 4 on wrong sync type.
// - Bit 3 on any invalid response word.
// - Bit 2 on RT-to-RT address, gap, status fault.
// - Bit 1 on bad second command word.
// - Bit 0 on undefined command word.
// - Gap field 0.5 us steps, saturating.
// - Marker one; sync and bus bits.
// - Contiguous bit suppresses gap field.
// - Two-word queue entry, bit 0 message type.
// - Message events carry status word pointer.
// - Non-message events carry zero or address.
// - Status word written to RAM at completion, unless a queue write takes that cycle.
// - Pointer base fixed, low location advances.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module status_report
  import status_report_pkg::*;
#(
  parameter int ADDR_W = 4             // Register port address width
) (
  input  wire logic                              clock,      // 200 MHz clock
  input  wire logic                              reset,      // Sync reset, active high
  input  wire status_report_pkg::msg_event_type  msg_evt,    // Message events
  input  wire status_report_pkg::word_event_type word_evt,   // Word monitor events
  input  wire status_report_pkg::irq_event_type  irq_evt,    // Interrupt events
  input  wire logic [15:0]                       stat_ptr,   // Block status word address
  input  wire logic [ADDR_W-1:0]                 reg_addr,   // Register address
  input  wire logic [15:0]                       reg_wdata,  // Register write data
  input  wire logic                              reg_wr,     // Write strobe
  input  wire logic                              reg_rd,     // Read strobe
  output status_report_pkg::ram_write_type       ram_wr,     // Shared RAM write
  output logic [15:0]                            reg_rdata   // Read data, next cycle
);
  import status_report_pkg::*;

  // Map needs three address bits
  if (ADDR_W < 3) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0]   msg_status_ff;    // Message status word being built
  logic [15:0]   tag_word_ff;      // Last word monitor tag word
  logic [15:0]   queue_ptr_ff;     // Queue pointer: base and location
  logic [15:0]   config_ff;        // Configuration bits
  logic [15:0]   queue_stat_ff;    // Last queue status word
  logic [15:0]   queue_parm_ff;    // Last queue parameter word
  logic [15:0]   resp_cnt_ff;      // Cycles since transfer start
  logic          resp_wait_ff;     // Waiting for transmitter response
  logic [15:0]   gap_cyc_ff;       // Cycle count within gap step
  logic [7:0]    gap_ff;           // Gap in 0.5 us steps
  logic          pend_parm_ff;     // Second queue word pending
  logic [15:0]   pend_val_ff;      // Parameter word held
  ram_write_type ram_wr_ff;        // Registered RAM write
  logic [15:0]   rdata_ff;         // Registered read data
  logic [15:0]   nxt_rdata;        // Read mux

  logic          monitor;          // Message monitor mode
  logic [15:0]   to_limit;         // Timeout in cycles
  logic          late;             // Response past timeout
  logic          early;            // Response before least gap

  assign monitor = config_ff[CFG_MONITOR];

  // Timeout selection from the two-bit config field
  always_comb begin
    case (config_ff[CFG_TO_LSB +: 2])
      2'h0:    to_limit = 16'(TO_US_0 * US_CYC);
      2'h1:    to_limit = 16'(TO_US_1 * US_CYC);
      2'h2:    to_limit = 16'(TO_US_2 * US_CYC);
      default: to_limit = 16'(TO_US_3 * US_CYC);
    endcase
  end

  // Window limits against the timer
  assign late  = resp_wait_ff && (resp_cnt_ff >= to_limit);
  assign early = config_ff[CFG_GAP_CHECK] && (resp_cnt_ff < 16'(MIN_RESP_CYC));

  // ---------------------------------------------------------------
  // Response timer for RT-to-RT transfers
  // ---------------------------------------------------------------
  // Counter saturates so that a silent transmitter never wraps to "early"
  always_ff @(posedge clock) begin
    if (reset || msg_evt.start) begin
      resp_cnt_ff <= 16'h0000;
    end else if (resp_cnt_ff != 16'hffff) begin
      resp_cnt_ff <= resp_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      resp_wait_ff <= 1'b0;
    end else if (msg_evt.start) begin
      resp_wait_ff <= msg_evt.rtrt;
    end else if (msg_evt.resp_seen || msg_evt.finish) begin
      resp_wait_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Message status word
  // ---------------------------------------------------------------
  // Error bits accumulate over the message; software may overwrite it
  always_ff @(posedge clock) begin
    if (reset) begin
      msg_status_ff <= 16'h0000;
    end else if (msg_evt.start) begin
      msg_status_ff                <= 16'h0000;
      msg_status_ff[MSW_ACTIVE]    <= 1'b1;
      msg_status_ff[MSW_BUS]       <= msg_evt.bus_b;
      msg_status_ff[MSW_RTRT_RX]   <= msg_evt.rtrt;
    end else begin
      // Events below override a host write
      if (reg_wr && reg_addr == ADDR_W'(REG_MSG_STATUS)) begin
        msg_status_ff <= reg_wdata;
      end
      if (msg_evt.finish) begin
        msg_status_ff[MSW_ACTIVE] <= 1'b0;
        msg_status_ff[MSW_DONE]   <= 1'b1;
        if (monitor) begin
          msg_status_ff[MSW_LOOPBACK] <= msg_evt.msg_valid;
        end
      end
      if (msg_evt.format_err) begin
        msg_status_ff[MSW_FORMAT] <= 1'b1;
        msg_status_ff[MSW_ERROR]  <= 1'b1;
      end
      if (late && !monitor) begin
        msg_status_ff[MSW_TIMEOUT] <= 1'b1;
        msg_status_ff[MSW_ERROR]   <= 1'b1;
      end
      if (!monitor && (msg_evt.loop_invalid || msg_evt.loop_mismatch)) begin
        msg_status_ff[MSW_LOOPBACK] <= 1'b1;
        msg_status_ff[MSW_ERROR]    <= 1'b1;
      end
      if (msg_evt.handshake_fail) begin
        msg_status_ff[MSW_ERROR] <= 1'b1;
      end
      if (msg_evt.buf_over && (!config_ff[CFG_ROLL_VALID] || msg_evt.msg_valid)) begin
        msg_status_ff[MSW_CIRC_RO] <= 1'b1;
      end
      if (msg_evt.illegal_cmd && !monitor) begin
        msg_status_ff[MSW_ILLEGAL] <= 1'b1;
      end
      if (msg_evt.wcount_err) begin
        msg_status_ff[MSW_WCOUNT] <= 1'b1;
      end
      if (msg_evt.sync_err) begin
        msg_status_ff[MSW_SYNC] <= 1'b1;
      end
      if (msg_evt.invalid_word) begin
        msg_status_ff[MSW_INVALID] <= 1'b1;
      end
      if (msg_evt.rtrt && (msg_evt.addr_mismatch || msg_evt.resp_bad_status
          || (msg_evt.resp_seen && resp_wait_ff && early))) begin
        msg_status_ff[MSW_RTRT_ERR] <= 1'b1;
      end
      if (msg_evt.cmd2_err) begin
        msg_status_ff[MSW_RTRT_CMD2] <= 1'b1;
      end
      if (msg_evt.undef_cmd) begin
        msg_status_ff[MSW_UNDEF_CMD] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Word monitor gap timer
  // ---------------------------------------------------------------
  // Counts from the end of one word to the start of the next
  always_ff @(posedge clock) begin
    if (reset || word_evt.word_end) begin
      gap_cyc_ff <= 16'h0000;
      gap_ff     <= 8'h00;
    end else if (gap_cyc_ff == 16'(GAP_LSB_CYC - 1)) begin
      gap_cyc_ff <= 16'h0000;
      if (gap_ff != GAP_MAX) begin
        gap_ff <= gap_ff + 8'h01;
      end
    end else begin
      gap_cyc_ff <= gap_cyc_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Word monitor tag word
  // ---------------------------------------------------------------
  logic [7:0] gap_hold_ff;    // Gap captured at word start
  // Frozen at sync, not at store
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_hold_ff <= 8'h00;
    end else if (word_evt.word_start) begin
      gap_hold_ff <= gap_ff;
    end
  end

  // Loads when the word is stored
  always_ff @(posedge clock) begin
    if (reset) begin
      tag_word_ff <= 16'h0000;
    end else if (word_evt.word_end) begin
      tag_word_ff[TAG_GAP_LSB +: 8] <= word_evt.contiguous ? 8'h00 : gap_hold_ff;
      tag_word_ff[TAG_MARKER]       <= 1'b1;
      tag_word_ff[TAG_CMD]          <= word_evt.rt_cmd_n;
      tag_word_ff[TAG_BROADCAST_COMMAND_FLAG]         <= word_evt.broadcast_command_flag_n;
      tag_word_ff[TAG_ERR]          <= word_evt.error;
      tag_word_ff[TAG_SYNC]         <= word_evt.cmd_sync;
      tag_word_ff[TAG_BUS]          <= word_evt.bus_b;
      tag_word_ff[TAG_CONTIG]       <= word_evt.contiguous;
      tag_word_ff[TAG_MODE]         <= word_evt.mode_n;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt queue pointer
  // ---------------------------------------------------------------
  logic q_write;   // A queue word goes to RAM this cycle
  assign q_write = irq_evt.valid || pend_parm_ff;

  // Queue advance beats a host write
  always_ff @(posedge clock) begin
    if (reset) begin
      queue_ptr_ff <= QP_RESET;
    end else if (q_write) begin
      // Low location wraps on its own width; base bits untouched
      queue_ptr_ff[QP_LOC_W-1:0] <= queue_ptr_ff[QP_LOC_W-1:0] + 6'h01;
    end else if (reg_wr && reg_addr == ADDR_W'(REG_QUEUE_PTR)) begin
      queue_ptr_ff <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt queue entry builder
  // ---------------------------------------------------------------
  // An event arriving while the parameter word is still pending is lost;
  // the source must space events at least two cycles apart.
  always_ff @(posedge clock) begin
    if (reset) begin
      pend_parm_ff  <= 1'b0;
      pend_val_ff   <= 16'h0000;
      queue_stat_ff <= 16'h0000;
      queue_parm_ff <= 16'h0000;
    end else if (pend_parm_ff) begin
      pend_parm_ff  <= 1'b0;
      queue_parm_ff <= pend_val_ff;
    end else if (irq_evt.valid) begin
      pend_parm_ff <= 1'b1;
      if (irq_evt.is_msg) begin
        queue_stat_ff <= {irq_evt.msg_bits, 1'b1};
        pend_val_ff   <= stat_ptr;
      end else begin
        queue_stat_ff <= {11'h000, irq_evt.nmsg_bits, 1'b0};
        pend_val_ff   <= irq_evt.nmsg_bits[QSW_RAM_PAR] ? irq_evt.param
                                                        : ZERO_PARAM;
      end
    end
  end

  // ---------------------------------------------------------------
  // Shared RAM write port
  // ---------------------------------------------------------------
  // Queue writes take priority; a finishing message writes its status
  always_ff @(posedge clock) begin
    if (reset) begin
      ram_wr_ff <= '0;
    end else if (pend_parm_ff) begin
      ram_wr_ff <= '{we: 1'b1, addr: queue_ptr_ff, data: pend_val_ff};
    end else if (irq_evt.valid) begin
      ram_wr_ff.we   <= 1'b1;
      ram_wr_ff.addr <= queue_ptr_ff;
      ram_wr_ff.data <= irq_evt.is_msg ? {irq_evt.msg_bits, 1'b1}
                                       : {11'h000, irq_evt.nmsg_bits, 1'b0};
    end else if (msg_evt.finish) begin
      ram_wr_ff.we   <= 1'b1;
      ram_wr_ff.addr <= stat_ptr;
      ram_wr_ff.data <= msg_status_ff;
    end else begin
      ram_wr_ff.we <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  // Written by the host alone
  always_ff @(posedge clock) begin
    if (reset) begin
      config_ff <= CFG_RESET;
    end else if (reg_wr && reg_addr == ADDR_W'(REG_CONFIG)) begin
      config_ff <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Decoded on the full address width
  always_comb begin
    case (reg_addr)
      ADDR_W'(REG_MSG_STATUS): nxt_rdata = msg_status_ff;
      ADDR_W'(REG_TAG_WORD):   nxt_rdata = tag_word_ff;
      ADDR_W'(REG_QUEUE_PTR):  nxt_rdata = queue_ptr_ff;
      ADDR_W'(REG_CONFIG):     nxt_rdata = config_ff;
      ADDR_W'(REG_QUEUE_STAT): nxt_rdata = queue_stat_ff;
      ADDR_W'(REG_QUEUE_PARM): nxt_rdata = queue_parm_ff;
      default:                 nxt_rdata = 16'h0000;  // Unmapped reads zero
    endcase
  end

  // Zero outside the one-cycle slot
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign ram_wr    = ram_wr_ff;
  assign reg_rdata = rdata_ff;

endmodule // status_report

//--- rtl/status_report_pkg.sv
// Package for the status-reporting block: field layouts, codes and bus offsets
package status_report_pkg;

  // ---------------------------------------------------------------
  // Message status word bit positions
  // ---------------------------------------------------------------
  localparam int MSW_DONE      = 15;
  localparam int MSW_ACTIVE    = 14;
  localparam int MSW_BUS       = 13;
  localparam int MSW_ERROR     = 12;
  localparam int MSW_RTRT_RX   = 11;
  localparam int MSW_FORMAT    = 10;
  localparam int MSW_TIMEOUT   = 9;
  localparam int MSW_LOOPBACK  = 8;
  localparam int MSW_CIRC_RO   = 7;
  localparam int MSW_ILLEGAL   = 6;
  localparam int MSW_WCOUNT    = 5;
  localparam int MSW_SYNC      = 4;
  localparam int MSW_INVALID   = 3;
  localparam int MSW_RTRT_ERR  = 2;
  localparam int MSW_RTRT_CMD2 = 1;
  localparam int MSW_UNDEF_CMD = 0;

  // ---------------------------------------------------------------
  // Word monitor tag word bit positions
  // ---------------------------------------------------------------
  localparam int TAG_GAP_LSB   = 8;
  localparam int TAG_MARKER    = 7;
  localparam int TAG_CMD       = 6;
  localparam int TAG_BROADCAST_COMMAND_FLAG      = 5;
  localparam int TAG_ERR       = 4;
  localparam int TAG_SYNC      = 3;
  localparam int TAG_BUS       = 2;
  localparam int TAG_CONTIG    = 1;
  localparam int TAG_MODE      = 0;

  // ---------------------------------------------------------------
  // Queue status word layout
  // ---------------------------------------------------------------
  localparam int QSW_MSG_FLAG  = 0;
  localparam int QSW_EVT_LSB   = 1;
  localparam int QSW_MSG_EVTS  = 15;
  localparam int QSW_NMSG_EVTS = 4;
  localparam int QSW_RAM_PAR   = 0;  // Index within non-message events
  localparam logic [15:0] ZERO_PARAM = 16'h0000;

  // ---------------------------------------------------------------
  // Queue pointer layout
  // ---------------------------------------------------------------
  localparam int QP_LOC_W      = 6;
  localparam logic [15:0] QP_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int GAP_LSB_PS     = 500000;   // 0.5 us per count
  localparam int GAP_LSB_CYC    = GAP_LSB_PS / CLK_PERIOD_PS;
  localparam logic [7:0] GAP_MAX = 8'hff;   // 127.5 us
  localparam int MIN_RESP_PS    = 4000000;  // 4 us least response
  localparam int MIN_RESP_CYC   = (MIN_RESP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_MSG_STATUS = 4'h0;
  localparam logic [3:0] REG_TAG_WORD   = 4'h1;
  localparam logic [3:0] REG_QUEUE_PTR  = 4'h2;
  localparam logic [3:0] REG_CONFIG     = 4'h3;
  localparam logic [3:0] REG_QUEUE_STAT = 4'h4;
  localparam logic [3:0] REG_QUEUE_PARM = 4'h5;

  // Config register bits
  localparam int CFG_ROLL_VALID = 11;
  localparam int CFG_GAP_CHECK  = 8;
  localparam int CFG_TO_LSB     = 9;   // Two-bit timeout select 10:9
  localparam int CFG_MONITOR    = 0;   // 1 = message monitor mode
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Timeout intervals per select code, in microseconds
  localparam int TO_US_0 = 18;
  localparam int TO_US_1 = 22;
  localparam int TO_US_2 = 50;
  localparam int TO_US_3 = 130;
  localparam int US_CYC  = 1000000 / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       start;        // Message begins
    logic       finish;       // Message ends
    logic       bus_b;        // Carried on second bus
    logic       rtrt;         // RT-to-RT transfer, this unit receives
    logic       format_err;
    logic       resp_seen;    // Transmitter response arrived this cycle
    logic       loop_invalid; // Looped word failed validity
    logic       loop_mismatch;// Last looped word differs
    logic       msg_valid;    // Monitor: message valid
    logic       buf_over;     // Circular buffer passed upper bound
    logic       illegal_cmd;
    logic       wcount_err;
    logic       sync_err;
    logic       invalid_word;
    logic       addr_mismatch;
    logic       resp_bad_status;
    logic       cmd2_err;
    logic       undef_cmd;
    logic       handshake_fail;
  } msg_event_type;

  typedef struct packed {
    logic       word_end;     // Word stored by the word monitor
    logic       word_start;   // Word sync seen
    logic       cmd_sync;
    logic       bus_b;
    logic       error;
    logic       rt_cmd_n;
    logic       broadcast_command_flag_n;
    logic       mode_n;
    logic       contiguous;
  } word_event_type;

  typedef struct packed {
    logic        valid;
    logic        is_msg;
    logic [14:0] msg_bits;    // Status bits 15..1
    logic [3:0]  nmsg_bits;   // Status bits 4..1
    logic [15:0] param;       // Failing address; message events use stat_ptr
  } irq_event_type;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } ram_write_type;

endpackage

//--- verification/status_report_props.sv
// Port checker for the status-reporting block
`timescale 1ns/10ps
module status_report_props
  import status_report_pkg::*;
(
  input wire logic                              clock,     // Clock
  input wire logic                              reset,     // Sync reset
  input wire status_report_pkg::msg_event_type  msg_evt,   // Message events
  input wire status_report_pkg::irq_event_type  irq_evt,   // Interrupt events
  input wire logic [15:0]                       stat_ptr,  // Status word address
  input wire logic                              reg_rd,    // Read strobe
  input wire status_report_pkg::ram_write_type  ram_wr,    // RAM write
  input wire logic [15:0]                       reg_rdata  // Read data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic fmt_ff; // Format fault seen since the message began
  // Remember a fault until the next start, since the RAM copy comes later
  always_ff @(posedge clock) begin
    if (reset || msg_evt.start) fmt_ff <= 1'b0;
    else if (msg_evt.format_err) fmt_ff <= 1'b1;
  end
  sequence stat_word_s;
    ram_wr.we && ram_wr.data[0] == $past(irq_evt.is_msg);
  endsequence
  sequence parm_word_s;
    ram_wr.we && ram_wr.data == ($past(irq_evt.is_msg, 2) ? $past(stat_ptr, 2)
      : $past(irq_evt.nmsg_bits[0], 2) ? $past(irq_evt.param, 2) : 16'h0000);
  endsequence
  q_entry_a: assert property (irq_evt.valid |=> stat_word_s ##1 parm_word_s)
    else $error("queue entry wrong");
  q_advance_a: assert property (irq_evt.valid |=> ##1
    ram_wr.addr == {$past(ram_wr.addr[15:6]), $past(ram_wr.addr[5:0]) + 6'h01})
    else $error("queue location wrong");
  q_msgbits_a: assert property (irq_evt.valid && irq_evt.is_msg |=>
    ram_wr.data[15:1] == $past(irq_evt.msg_bits)) else $error("message bits wrong");
  q_nmsgbits_a: assert property (irq_evt.valid && !irq_evt.is_msg |=>
    ram_wr.data[15:5] == 11'h000 && ram_wr.data[4:1] == $past(irq_evt.nmsg_bits))
    else $error("event bits wrong");
  stat_write_a: assert property (msg_evt.finish && !irq_evt.valid && !$past(irq_evt.valid)
    |=> ram_wr.we && ram_wr.addr == $past(stat_ptr)) else $error("status not written");
  stat_bus_a: assert property (msg_evt.finish && !irq_evt.valid && !$past(irq_evt.valid)
    |=> ram_wr.data[13] == $past(msg_evt.bus_b)) else $error("bus bit wrong");
  stat_fmt_a: assert property (msg_evt.finish && fmt_ff && !irq_evt.valid
    && !$past(irq_evt.valid) |=> ram_wr.data[12] && ram_wr.data[10])
    else $error("format fault lost");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside slot");
endmodule // status_report_props
bind status_report status_report_props u_props (.clock(clock), .reset(reset),
  .msg_evt(msg_evt), .irq_evt(irq_evt), .stat_ptr(stat_ptr), .reg_rd(reg_rd),
  .ram_wr(ram_wr), .reg_rdata(reg_rdata));

//--- verification/rt_bus_partner.sv
// Far-side model: a bus controller running one message at a time
`timescale 1ns/10ps
module rt_bus_partner
  import status_report_pkg::*;
(
  input  wire logic                             clock, // Clock
  input  wire logic                             go,    // Begin one message
  input  wire logic                             bus_b, // Bus B when high
  input  wire logic                             fault, // Inject a format fault
  input  wire logic [7:0]                       gap,   // Word spacing, cycles
  output status_report_pkg::msg_event_type      evt,   // Message events
  output logic                                  busy   // Message in flight
);
  // Bus level flips once released, so no stale value is mistaken for data
  initial begin
    evt = '0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy <= 1'b1;
        evt.start <= 1'b1;
        evt.bus_b <= bus_b;
        @(posedge clock);
        evt.start <= 1'b0;
        repeat (gap) @(posedge clock);
        evt.format_err <= fault;
        @(posedge clock);
        evt.format_err <= 1'b0;
        repeat (gap) @(posedge clock);
        evt.finish <= 1'b1;
        @(posedge clock);
        evt.finish <= 1'b0;
        evt.bus_b <= ~bus_b;
        busy <= 1'b0;
      end
    end
  end
endmodule // rt_bus_partner

//--- verification/tb_top.sv
// Self-checking bench for the status-reporting block
`timescale 1ns/10ps
module tb_top;
  import status_report_pkg::*;
  typedef struct packed {
    logic [15:0] addr; // Expected address, zero for reads
    logic [15:0] data; // Expected value
    logic [15:0] mask; // Bits compared
  } exp_type;
  logic clock, reset, reg_wr, reg_rd, go, bus, flt, rd_d, busy;
  logic [7:0] gap;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, stat_ptr, reg_rdata, qp;
  msg_event_type msg_evt;
  word_event_type word_evt;
  irq_event_type irq_evt;
  ram_write_type ram_wr;
  exp_type rd_q[$], wr_q[$];
  int n_fail, checked, seed, i;
  status_report uut (.clock(clock), .reset(reset), .msg_evt(msg_evt), .word_evt(word_evt),
    .irq_evt(irq_evt), .stat_ptr(stat_ptr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .ram_wr(ram_wr), .reg_rdata(reg_rdata));
  rt_bus_partner peer (.clock(clock), .go(go), .bus_b(bus), .fault(flt), .gap(gap),
    .evt(msg_evt), .busy(busy));
  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] ga, input logic [15:0] gd, ref exp_type q[$]);
    exp_type e;
    checked++;
    if (q.size() == 0) begin
      n_fail++;
      $display("[ERR] %0t unexpected result %h", $time, gd);
    end else begin
      e = q.pop_front();
      if (ga !== e.addr || (gd & e.mask) !== (e.data & e.mask)) begin
        n_fail++;
        $display("[ERR] %0t got %h:%h want %h:%h", $time, ga, gd, e.addr, e.data);
      end
    end
  endtask
  // Watcher: read data stands only in the slot after the strobe
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d) chk(16'h0000, reg_rdata, rd_q);
    if (ram_wr.we === 1'b1) chk(ram_wr.addr, ram_wr.data, wr_q);
  end
  task automatic report_and_stop;
    if (rd_q.size() + wr_q.size() != 0) n_fail++;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] m);
    rd_q.push_back('{16'h0000, d, m});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic msg(input logic b, input logic f, input logic [15:0] p);
    int k;
    wr_q.push_back('{p, {2'b00, b, f, 1'b0, f, 10'h000}, 16'h3fff});
    bus <= b;
    flt <= f;
    stat_ptr <= p;
    gap <= 8'h01 + 8'({$random(seed)} % 32);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge clock);
    if (busy !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    rd(REG_MSG_STATUS, {1'b1, 1'b0, b, f, 1'b0, f, 10'h000}, 16'hffff);
  endtask
  task automatic irq(input logic m, input logic [14:0] b, input logic [3:0] n,
                     input logic [15:0] p);
    wr_q.push_back('{qp, m ? {b, 1'b1} : {11'h000, n, 1'b0}, 16'hffff});
    qp[5:0] = qp[5:0] + 6'h01;
    wr_q.push_back('{qp, p, 16'hffff});
    qp[5:0] = qp[5:0] + 6'h01;
    irq_evt <= '{1'b1, m, b, n, (m || !n[0]) ? ~p : p};
    @(posedge clock);
    irq_evt <= '0;
    repeat (2) @(posedge clock);
  endtask
  task automatic wd(input logic c, input logic b, input logic t);
    word_evt <= '{1'b0, 1'b1, c, b, 1'b0, 1'b1, 1'b1, 1'b1, t};
    @(posedge clock);
    word_evt <= '{1'b1, 1'b0, c, b, 1'b0, 1'b1, 1'b1, 1'b1, t};
    @(posedge clock);
    word_evt <= '0;
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 38;
    reset = 1'b1;
    {reg_wr, reg_rd, go, bus, flt, rd_d} = '0;
    {gap, reg_addr, reg_wdata, stat_ptr, qp} = '0;
    word_evt = '0;
    irq_evt = '0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(REG_MSG_STATUS, 16'h0000, 16'hffff);
    rd(REG_QUEUE_PTR, 16'h0000, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    wr(REG_CONFIG, 16'h0f01);
    rd(REG_CONFIG, 16'h0f01, 16'h0f01);
    wr(REG_CONFIG, 16'h0000);
    $display("register test done");
    // Every bus and fault pairing, with random spacing and pointer
    for (i = 0; i < 4; i++) msg(i[1], i[0], 16'($random(seed)));
    $display("message test done");
    // Start one entry below the wrap so the location wraps
    wr(REG_QUEUE_PTR, 16'h03fe);
    qp = 16'h03fe;
    irq(1'b1, 15'($random(seed)), 4'h0, stat_ptr);
    for (i = 0; i < 4; i++) irq(1'b0, 15'h0000, 4'(1 << i),
      i == 0 ? 16'($random(seed)) : ZERO_PARAM);
    rd(REG_QUEUE_PTR, qp, 16'hffff);
    rd(REG_QUEUE_STAT, 16'h0010, 16'hffff);
    rd(REG_QUEUE_PARM, ZERO_PARAM, 16'hffff);
    $display("queue test done");
    wd(1'b1, 1'b1, 1'b0);
    repeat (250) @(posedge clock);
    wd(1'b1, 1'b1, 1'b0);
    rd(REG_TAG_WORD, 16'h02ed, 16'hffff);
    wd(1'b0, 1'b0, 1'b1);
    rd(REG_TAG_WORD, 16'h00e3, 16'h00ff);
    $display("word monitor test done");
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule // tb_top
